// >>> sre_params.svh
// Offsets, field positions, reset values, opcodes and cycle counts of the stack and rotate unit
`ifndef SRE_PARAMS_SVH
`define SRE_PARAMS_SVH
`define SRE_OFS_CMD       8'h00
`define SRE_OFS_FLAGS     8'h04
`define SRE_OFS_SP        8'h08
`define SRE_OFS_PC        8'h0c
`define SRE_OFS_STATUS    8'h10
`define SRE_OFS_RF_IDX    8'h14
`define SRE_OFS_RF_DATA   8'h18
`define SRE_FLAG_C        7
`define SRE_FLAG_Z        6
`define SRE_FLAG_S        5
`define SRE_FLAG_V        4
`define SRE_FLAG_D        3
`define SRE_FLAG_H        2
`define SRE_STAT_BUSY     0
`define SRE_STAT_BAD      1
`define SRE_RST_FLAGS     8'h00
`define SRE_RST_SP        16'h0000
`define SRE_RST_PC        16'h0000
`define SRE_OPC_PUSH_R    8'h70
`define SRE_OPC_PUSH_IR   8'h71
`define SRE_OPC_UPUSH_DN  8'h82
`define SRE_OPC_UPUSH_UP  8'h83
`define SRE_OPC_CLRC      8'hcf
`define SRE_OPC_EXIT      8'haf
`define SRE_OPC_ROTL_R    8'h90
`define SRE_OPC_ROTL_IR   8'h91
`define SRE_OPC_ROTLC_R   8'h10
`define SRE_OPC_ROTLC_IR  8'h11
`define SRE_OPC_ROTR_R    8'he0
`define SRE_OPC_ROTR_IR   8'he1
`define SRE_OPC_ROTRC_R   8'hc0
`define SRE_OPC_ROTRC_IR  8'hc1
`define SRE_CYC_PUSH      4'h8
`define SRE_CYC_EXIT      4'h8
`define SRE_CYC_SHORT     4'h4
`endif

// >>> sre_pkg.sv
// Types shared by the stack and rotate unit
package sre_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PTR  = 2'b01,
        ST_XFER = 2'b10,
        ST_WAIT = 2'b11
    } sre_state_type;

    typedef struct packed {
        logic [7:0] op2;
        logic [7:0] op1;
        logic [7:0] opcode;
    } sre_cmd_type;
endpackage

// >>> sre_exec_unit.sv
// Stack push, subroutine exit, carry clear and rotate execution unit with Avalon-MM registers
// Notes on behaviour
// - System push decrements 16-bit stack pointer with wrap, then stores source byte.
// - Opcode 71 pushes the byte addressed by the named register, 8 cycles.
// - Opcode 82 decrements register-held pointer, then stores source there; 8 cycles.
// - Opcode 83 increments register-held pointer, then stores source there; 8 cycles.
// - User stacks live in the register file; pointer indirect, source a register.
// - Pushes and subroutine exit leave every flag unchanged.
// - Opcode CF clears carry only, 4 cycles.
// - Opcode AF loads program counter from stack, then adds 2 to pointer.
// - Lower stack byte is program counter high byte, next byte the low.
// - Opcodes 90/91 rotate left, bit 7 to bit 0 and carry, 4 cycles.
// - Opcodes 10/11 rotate left through carry, 4 cycles.
// - Opcodes E0/E1 rotate right, bit 0 to bit 7 and carry, 4 cycles.
// - Opcode C0 rotates right through carry on a register, 4 cycles.
// - Rotates set zero on zero result; sign copies result bit 7.
// - Rotates set overflow on sign change; decimal and half carry kept.
// - Opcode C1 rotates right through carry on an indirect register, 4 cycles.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`include "sre_params.svh"
module sre_exec_unit #(
    parameter int unsigned RF_AW       = 8,
    parameter logic [3:0]  EXIT_CYCLES = `SRE_CYC_EXIT
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic             CORE_BUSY,
    output logic      [15:0] CORE_PC,
    output logic      [15:0] CORE_SP,
    output logic      [7:0]  CORE_FLAGS
);

    localparam int RF_N = 1 << RF_AW;

    function automatic logic [RF_AW-1:0] ridx(input logic [15:0] a);
        return a[RF_AW-1:0];
    endfunction

    function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] cycles_of(input logic [7:0] opc, input logic [3:0] exit_c);
        case (opc)
            `SRE_OPC_PUSH_R, `SRE_OPC_PUSH_IR:      return `SRE_CYC_PUSH;
            `SRE_OPC_UPUSH_DN, `SRE_OPC_UPUSH_UP:   return `SRE_CYC_PUSH;
            `SRE_OPC_EXIT:                          return exit_c;
            `SRE_OPC_CLRC:                          return `SRE_CYC_SHORT;
            `SRE_OPC_ROTL_R, `SRE_OPC_ROTL_IR:      return `SRE_CYC_SHORT;
            `SRE_OPC_ROTLC_R, `SRE_OPC_ROTLC_IR:    return `SRE_CYC_SHORT;
            `SRE_OPC_ROTR_R, `SRE_OPC_ROTR_IR:      return `SRE_CYC_SHORT;
            `SRE_OPC_ROTRC_R, `SRE_OPC_ROTRC_IR:    return `SRE_CYC_SHORT;
            default:                           return 4'h0;
        endcase
    endfunction

    logic [7:0]                 rf_reg [RF_N];
    sre_pkg::sre_state_type     state_reg;
    sre_pkg::sre_state_type     state_next;
    sre_pkg::sre_cmd_type       cmd_reg;
    logic [3:0]                 cyc_reg;
    logic [3:0]                 cnt_reg;
    logic [15:0]                sp_reg;
    logic [15:0]                pc_reg;
    logic [7:0]                 flags_reg;
    logic [7:0]                 ea_reg;
    logic [7:0]                 rf_idx_reg;
    logic                       bad_reg;
    logic                       rd_ack_reg;
    logic [31:0]                rdata_reg;
    logic [7:0]                 rot_flags;
    logic [7:0]                 clr_flags;

    // Bus decode
    wire        busy      = (state_reg != sre_pkg::ST_IDLE);
    wire        bus_stall = busy && AVS_WRITE;
    wire        wr_ok     = AVS_WRITE && !bus_stall;
    wire        rd_first  = AVS_READ && !rd_ack_reg;
    wire        wr_cmd    = wr_ok && (AVS_ADDRESS == `SRE_OFS_CMD);
    wire        wr_flags  = wr_ok && (AVS_ADDRESS == `SRE_OFS_FLAGS);
    wire        wr_sp     = wr_ok && (AVS_ADDRESS == `SRE_OFS_SP);
    wire        wr_pc     = wr_ok && (AVS_ADDRESS == `SRE_OFS_PC);
    wire        wr_idx    = wr_ok && (AVS_ADDRESS == `SRE_OFS_RF_IDX);
    wire        wr_data   = wr_ok && (AVS_ADDRESS == `SRE_OFS_RF_DATA);
    wire [31:0] cmd_word  = bmerge({8'h00, cmd_reg}, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire [31:0] flg_word  = bmerge({24'h000000, flags_reg}, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire [31:0] sp_word   = bmerge({16'h0000, sp_reg}, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire [31:0] pc_word   = bmerge({16'h0000, pc_reg}, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire [31:0] idx_word  = bmerge({24'h000000, rf_idx_reg}, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire [7:0]  rf_win    = rf_reg[ridx({8'h00, rf_idx_reg})];
    wire [31:0] dat_word  = bmerge({24'h000000, rf_win}, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire [3:0]  start_cyc = cycles_of(cmd_word[7:0], EXIT_CYCLES);
    wire        start     = wr_cmd && (start_cyc != 4'h0);

    // Instruction decode
    wire [7:0]  opc       = cmd_reg.opcode;
    wire        is_push   = (opc == `SRE_OPC_PUSH_R) || (opc == `SRE_OPC_PUSH_IR);
    wire        is_pud    = (opc == `SRE_OPC_UPUSH_DN);
    wire        is_pui    = (opc == `SRE_OPC_UPUSH_UP);
    wire        is_exit   = (opc == `SRE_OPC_EXIT);
    wire        is_clrc   = (opc == `SRE_OPC_CLRC);
    wire        is_rotl   = ({opc[7:1], 1'b0} == `SRE_OPC_ROTL_R);
    wire        is_rotlc  = ({opc[7:1], 1'b0} == `SRE_OPC_ROTLC_R);
    wire        is_rotr   = ({opc[7:1], 1'b0} == `SRE_OPC_ROTR_R);
    wire        is_rotrc  = ({opc[7:1], 1'b0} == `SRE_OPC_ROTRC_R);
    wire        is_rot    = is_rotl || is_rotlc || is_rotr || is_rotrc;
    wire        ind_rot   = is_rot && opc[0];

    // Operand fetch
    wire [7:0]  op1_val   = rf_reg[ridx({8'h00, cmd_reg.op1})];
    wire [7:0]  op2_val   = rf_reg[ridx({8'h00, cmd_reg.op2})];
    wire [7:0]  ea_val    = rf_reg[ridx({8'h00, ea_reg})];
    wire [7:0]  stk_val   = rf_reg[ridx(sp_reg)];
    wire [15:0] sp_inc    = sp_reg + 16'h0001;
    wire [7:0]  stk_nxt   = rf_reg[ridx(sp_inc)];
    wire [15:0] sp_dec    = sp_reg - 16'h0001;
    wire [7:0]  uptr_new  = is_pud ? (op1_val - 8'h01) : (op1_val + 8'h01);
    wire [7:0]  push_src  = (opc == `SRE_OPC_PUSH_IR) ? op1_val : cmd_reg.op1;
    wire [7:0]  rot_ea    = ind_rot ? op1_val : cmd_reg.op1;

    // Rotate datapath
    wire        c_old     = flags_reg[`SRE_FLAG_C];
    wire [7:0]  rot_res   = is_rotl  ? {ea_val[6:0], ea_val[7]} :
                            is_rotlc ? {ea_val[6:0], c_old} :
                            is_rotr  ? {ea_val[0], ea_val[7:1]} :
                                       {c_old, ea_val[7:1]};
    wire        rot_c     = (is_rotl || is_rotlc) ? ea_val[7] : ea_val[0];

    always_comb begin
        rot_flags = flags_reg;
        rot_flags[`SRE_FLAG_C] = rot_c;
        rot_flags[`SRE_FLAG_Z] = (rot_res == 8'h00);
        rot_flags[`SRE_FLAG_S] = rot_res[7];
        rot_flags[`SRE_FLAG_V] = ea_val[7] ^ rot_res[7];
        clr_flags = flags_reg;
        clr_flags[`SRE_FLAG_C] = 1'b0;
    end

    // Sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            sre_pkg::ST_IDLE: begin
                if (start) begin
                    state_next = sre_pkg::ST_PTR;
                end
            end
            sre_pkg::ST_PTR: begin
                state_next = sre_pkg::ST_XFER;
            end
            sre_pkg::ST_XFER: begin
                state_next = sre_pkg::ST_WAIT;
            end
            sre_pkg::ST_WAIT: begin
                if (cnt_reg == cyc_reg) begin
                    state_next = sre_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_reg <= sre_pkg::ST_IDLE;
            cnt_reg   <= 4'h0;
            cyc_reg   <= 4'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= start ? 4'h1 : (busy ? cnt_reg + 4'h1 : 4'h0);
            cyc_reg   <= start ? start_cyc : cyc_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cmd_reg    <= '0;
            bad_reg    <= 1'b0;
            rf_idx_reg <= 8'h00;
            ea_reg     <= 8'h00;
        end else begin
            if (wr_cmd) begin
                cmd_reg <= cmd_word[23:0];
                bad_reg <= (start_cyc == 4'h0);
            end
            if (wr_idx) begin
                rf_idx_reg <= idx_word[7:0];
            end
            if (state_reg == sre_pkg::ST_PTR) begin
                ea_reg <= is_push ? push_src : ((is_pud || is_pui) ? uptr_new : rot_ea);
            end
        end
    end

    // Pointer, program counter and flags
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sp_reg    <= `SRE_RST_SP;
            pc_reg    <= `SRE_RST_PC;
            flags_reg <= `SRE_RST_FLAGS;
        end else if (state_reg == sre_pkg::ST_PTR) begin
            if (is_push) begin
                sp_reg <= sp_dec;
            end
            if (is_exit) begin
                pc_reg[15:8] <= stk_val;
            end
        end else if (state_reg == sre_pkg::ST_XFER) begin
            if (is_exit) begin
                pc_reg[7:0] <= stk_nxt;
                sp_reg      <= sp_reg + 16'h0002;
            end
            if (is_rot) begin
                flags_reg <= rot_flags;
            end else if (is_clrc) begin
                flags_reg <= clr_flags;
            end
        end else begin
            if (wr_sp) begin
                sp_reg <= sp_word[15:0];
            end
            if (wr_pc) begin
                pc_reg <= pc_word[15:0];
            end
            if (wr_flags) begin
                flags_reg <= flg_word[7:0];
            end
        end
    end

    // Register file and internal stack
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            for (int i = 0; i < RF_N; i++) begin
                rf_reg[i] <= 8'h00;
            end
        end else if (state_reg == sre_pkg::ST_PTR) begin
            if (is_pud || is_pui) begin
                rf_reg[ridx({8'h00, cmd_reg.op1})] <= uptr_new;
            end
        end else if (state_reg == sre_pkg::ST_XFER) begin
            if (is_push) begin
                rf_reg[ridx(sp_reg)] <= ea_val;
            end else if (is_pud || is_pui) begin
                rf_reg[ridx({8'h00, ea_reg})] <= op2_val;
            end else if (is_rot) begin
                rf_reg[ridx({8'h00, ea_reg})] <= rot_res;
            end
        end else if (wr_data) begin
            rf_reg[ridx({8'h00, rf_idx_reg})] <= dat_word[7:0];
        end
    end

    // Read path with one wait cycle
    wire [31:0] rd_mux = (AVS_ADDRESS == `SRE_OFS_CMD)     ? {8'h00, cmd_reg} :
                         (AVS_ADDRESS == `SRE_OFS_FLAGS)   ? {24'h000000, flags_reg} :
                         (AVS_ADDRESS == `SRE_OFS_SP)      ? {16'h0000, sp_reg} :
                         (AVS_ADDRESS == `SRE_OFS_PC)      ? {16'h0000, pc_reg} :
                         (AVS_ADDRESS == `SRE_OFS_STATUS)  ? {30'h0, bad_reg, busy} :
                         (AVS_ADDRESS == `SRE_OFS_RF_IDX)  ? {24'h000000, rf_idx_reg} :
                         (AVS_ADDRESS == `SRE_OFS_RF_DATA) ? {24'h000000, rf_win} :
                                                             32'h00000000;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rd_ack_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
        end else begin
            rd_ack_reg <= rd_first;
            if (rd_first) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign AVS_WAITREQUEST = bus_stall || rd_first;
    assign AVS_READDATA    = rdata_reg;
    assign CORE_BUSY       = busy;
    assign CORE_PC         = pc_reg;
    assign CORE_SP         = sp_reg;
    assign CORE_FLAGS      = flags_reg;

    AST_PUSH_DEC: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == sre_pkg::ST_PTR && is_push) |=> (sp_reg == $past(sp_reg) - 16'h0001))
        else $error("push did not decrement the stack pointer");

    AST_PUSH_STORE: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == sre_pkg::ST_XFER && is_push) |=> (rf_reg[ridx(sp_reg)] == $past(ea_val)))
        else $error("push did not store the source byte at the new top");

    AST_PUSH_IND: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == sre_pkg::ST_PTR && opc == `SRE_OPC_PUSH_IR) |=> (ea_reg == $past(op1_val)))
        else $error("indirect push used the wrong source address");

    AST_PUSH_CYC: assert property (@(posedge CLK) disable iff (!RST_N)
        ($rose(busy) && (is_push || is_pud || is_pui)) |-> busy [*8] ##1 !busy)
        else $error("push did not take eight cycles");

    AST_PUD_PTR: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == sre_pkg::ST_PTR && is_pud) |=> (ea_reg == $past(op1_val) - 8'h01))
        else $error("decrementing user push pointer wrong");

    AST_PUI_PTR: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == sre_pkg::ST_PTR && is_pui) |=> (ea_reg == $past(op1_val) + 8'h01))
        else $error("incrementing user push pointer wrong");

    AST_UPUSH_STORE: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == sre_pkg::ST_XFER && (is_pud || is_pui))
        |=> (rf_reg[ridx({8'h00, $past(ea_reg)})] == $past(op2_val)))
        else $error("user push did not store the source register");

    AST_FLAGS_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
        (busy && (is_push || is_pud || is_pui || is_exit)) |=> $stable(flags_reg))
        else $error("stack instruction changed a flag");

    AST_CLRC: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == sre_pkg::ST_XFER && is_clrc)
        |=> (!flags_reg[`SRE_FLAG_C] && (flags_reg | 8'h80) == ($past(flags_reg) | 8'h80)))
        else $error("carry clear wrong or disturbed other flags");

    AST_EXIT_SP: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == sre_pkg::ST_XFER && is_exit)
        |=> (sp_reg == $past(sp_reg) + 16'h0002 && pc_reg[7:0] == $past(stk_nxt)))
        else $error("subroutine exit pointer or low byte wrong");

    AST_EXIT_HI: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == sre_pkg::ST_PTR && is_exit) |=> (pc_reg[15:8] == $past(stk_val)))
        else $error("subroutine exit high byte wrong");

    AST_ROTL: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == sre_pkg::ST_XFER && is_rotl)
        |=> (rf_reg[ridx({8'h00, $past(ea_reg)})] == {$past(ea_val[6:0]), $past(ea_val[7])}
             && flags_reg[`SRE_FLAG_C] == $past(ea_val[7])))
        else $error("rotate left result wrong");

    AST_ROTRC: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == sre_pkg::ST_XFER && is_rotrc)
        |=> (rf_reg[ridx({8'h00, $past(ea_reg)})] == {$past(flags_reg[`SRE_FLAG_C]), $past(ea_val[7:1])}))
        else $error("rotate right through carry result wrong");

    AST_ROT_CYC: assert property (@(posedge CLK) disable iff (!RST_N)
        ($rose(busy) && (is_rot || is_clrc)) |-> busy [*4] ##1 !busy)
        else $error("short instruction did not take four cycles");

    AST_ROT_ZS: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == sre_pkg::ST_XFER && is_rot)
        |=> (flags_reg[`SRE_FLAG_Z] == ($past(rot_res) == 8'h00) && flags_reg[`SRE_FLAG_S] == $past(rot_res[7])))
        else $error("rotate zero or sign flag wrong");

    AST_ROT_V: assert property (@(posedge CLK) disable iff (!RST_N)
        (state_reg == sre_pkg::ST_XFER && is_rot)
        |=> (flags_reg[`SRE_FLAG_V] == ($past(ea_val[7]) ^ $past(rot_res[7]))
             && flags_reg[3:2] == $past(flags_reg[3:2])))
        else $error("rotate overflow wrong or decimal and half carry disturbed");

endmodule

// >>> sre_seq_model.sv
// Avalon-MM master standing in for the instruction sequencer
module sre_seq_model (
    input  wire logic        CLK,
    input  wire logic        AVS_WAITREQUEST,
    output logic      [7:0]  AVS_ADDRESS,
    output logic             AVS_READ,
    output logic             AVS_WRITE,
    output logic      [31:0] AVS_WRITEDATA,
    output logic      [3:0]  AVS_BYTEENABLE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       hung;
    logic [3:0] lanes;
    initial begin
        lanes = 4'hf;
        AVS_ADDRESS = 8'h00;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_WRITEDATA = 32'h0;
        AVS_BYTEENABLE = 4'hf;
        hung = 1'b0;
    end
    // One transfer, held until waitrequest is seen low at a falling edge
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d);
        logic wt;
        int n;
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_READ <= rd;
        AVS_WRITE <= ~rd;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= lanes;
        wt = 1'b1;
        n = 0;
        while (wt === 1'b1 && n < 200) begin
            @(negedge CLK);
            wt = AVS_WAITREQUEST;
            @(posedge CLK);
            n++;
        end
        hung = hung | (wt !== 1'b0);
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        AVS_ADDRESS <= ~a;
        AVS_WRITEDATA <= ~d;
    endtask
endmodule

// >>> sre_exec_unit_bench.sv
// Self-checking bench for the stack and rotate execution unit
`include "sre_params.svh"
module sre_exec_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        rst_n;
    logic [7:0]  adr;
    logic        rd_s;
    logic        wr_s;
    logic [31:0] wdat;
    logic [3:0]  be;
    logic [31:0] rdat;
    logic        wt;
    logic        busy;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0]  fl;
    logic [31:0] exp_q[$];
    int          num_errors;
    int          comparisons;
    logic [7:0]  v, f, res, nf;
    logic        c;
    logic [7:0]  ops [8] = '{8'h90, 8'h91, 8'h10, 8'h11, 8'he0, 8'he1, 8'hc0, 8'hc1};

    sre_exec_unit #(.RF_AW(8), .EXIT_CYCLES(`SRE_CYC_EXIT)) sre_exec_unit_inst (.CLK(clk), .RST_N(rst_n),
        .AVS_ADDRESS(adr), .AVS_READ(rd_s), .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wt), .CORE_BUSY(busy), .CORE_PC(pc), .CORE_SP(sp),
        .CORE_FLAGS(fl));
    sre_seq_model sre_seq_model_inst (.CLK(clk), .AVS_WAITREQUEST(wt), .AVS_ADDRESS(adr), .AVS_READ(rd_s),
        .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        comparisons++;
        if (got !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
        end
    endtask

    // Read data taken at the edge where waitrequest is low
    always @(negedge clk) begin
        if (rd_s === 1'b1 && wt === 1'b0 && exp_q.size() > 0) begin
            chk(rdat, exp_q.pop_front());
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sre_seq_model_inst.xfer(1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        sre_seq_model_inst.xfer(1'b1, a, 32'h0);
    endtask
    task automatic rf_set(input logic [7:0] i, input logic [7:0] d);
        wr(`SRE_OFS_RF_IDX, {24'h0, i});
        wr(`SRE_OFS_RF_DATA, {24'h0, d});
    endtask
    task automatic rf_chk(input logic [7:0] i, input logic [7:0] e);
        wr(`SRE_OFS_RF_IDX, {24'h0, i});
        rd(`SRE_OFS_RF_DATA, {24'h0, e});
    endtask
    // Issue an instruction and count its busy cycles
    task automatic cmd(input logic [7:0] o, input logic [7:0] a1, input logic [7:0] a2, input int n);
        int k;
        wr(`SRE_OFS_CMD, {8'h00, a2, a1, o});
        k = 0;
        @(negedge clk);
        while (busy === 1'b1 && k < 50) begin
            k++;
            @(negedge clk);
        end
        chk(k, n);
    endtask

    task automatic conclude;
        if (sre_seq_model_inst.hung !== 1'b0) num_errors++;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        num_errors = 0;
        comparisons = 0;
        void'($urandom(32'hca5c));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(`SRE_OFS_SP, 32'h0);
        rd(`SRE_OFS_PC, 32'h0);
        rd(8'h1c, 32'h0);
        f = 8'($urandom);
        wr(`SRE_OFS_FLAGS, {24'h0, f});
        rf_set(8'h40, 8'h4f);
        rf_set(8'h4f, 8'haa);
        wr(`SRE_OFS_SP, 32'h0);
        cmd(8'h70, 8'h40, 8'h00, 8);
        chk({16'h0, sp}, 32'hffff);
        rd(`SRE_OFS_SP, 32'hffff);
        rf_chk(8'hff, 8'h4f);
        wr(`SRE_OFS_CMD, 32'h0000_4070);
        cmd(8'h71, 8'h40, 8'h00, 8);
        rd(`SRE_OFS_SP, 32'hfffd);
        rf_chk(8'hfe, 8'h4f);
        rf_chk(8'hfd, 8'haa);
        v = 8'($urandom);
        rf_set(8'h00, 8'h03);
        rf_set(8'h01, v);
        cmd(8'h82, 8'h00, 8'h01, 8);
        rf_chk(8'h00, 8'h02);
        rf_chk(8'h02, v);
        rf_set(8'h00, 8'h03);
        cmd(8'h83, 8'h00, 8'h01, 8);
        rf_chk(8'h00, 8'h04);
        rf_chk(8'h04, v);
        rd(`SRE_OFS_FLAGS, {24'h0, f});
        wr(`SRE_OFS_FLAGS, {24'h0, f | 8'h80});
        cmd(8'hcf, 8'h00, 8'h00, 4);
        rd(`SRE_OFS_FLAGS, {24'h0, f & 8'h7f});
        wr(`SRE_OFS_SP, 32'h00fc);
        rf_set(8'hfc, 8'h10);
        rf_set(8'hfd, 8'h1a);
        cmd(8'haf, 8'h00, 8'h00, 8);
        rd(`SRE_OFS_PC, 32'h101a);
        rd(`SRE_OFS_SP, 32'h00fe);
        chk({16'h0, pc}, 32'h101a);
        chk({16'h0, sp}, 32'h00fe);
        cmd(8'hff, 8'h00, 8'h00, 0);
        rd(`SRE_OFS_STATUS, 32'h2);
        rd(`SRE_OFS_FLAGS, {24'h0, f & 8'h7f});
        sre_seq_model_inst.lanes = 4'h1;
        wr(`SRE_OFS_SP, 32'h0000_12ab);
        sre_seq_model_inst.lanes = 4'hf;
        rd(`SRE_OFS_SP, 32'h00ab);
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 8; i++) begin
                v = (p == 0) ? 8'h00 : 8'($urandom);
                f = (p == 0) ? 8'h00 : 8'($urandom);
                rf_set(8'h20, 8'h30);
                rf_set(8'h30, v);
                wr(`SRE_OFS_FLAGS, {24'h0, f});
                case (ops[i][7:4])
                    4'h9: res = {v[6:0], v[7]};
                    4'h1: res = {v[6:0], f[7]};
                    4'he: res = {v[0], v[7:1]};
                    default: res = {f[7], v[7:1]};
                endcase
                c = ops[i][6] ? v[0] : v[7];
                nf = {c, res == 8'h00, res[7], res[7] ^ v[7], f[3:0]};
                cmd(ops[i], ops[i][0] ? 8'h20 : 8'h30, 8'h00, 4);
                rf_chk(8'h30, res);
                rd(`SRE_OFS_FLAGS, {24'h0, nf});
                chk({24'h0, fl}, {24'h0, nf});
            end
        end
        conclude();
    end
endmodule
